/* hw/pisx_checker.sv */
/*
 Prefix and exception checker for packed-integer SIMD instructions.
 Assumes the front end presents one instruction per valid cycle and holds it
 until ready; the address unit reports memory faults alongside.
*/
`timescale 1ns/100ps
module pisx_checker #(
   parameter int MAX_PFX = 8
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic instr_valid_i,
   input wire pisx_pkg::pisx_instr_t instr_i,
   input wire pisx_pkg::pisx_mem_fault_t mem_fault_i,
   input wire logic fp_exc_pending_i,
   input wire logic use_int16_i,
   input wire logic use_err_pin_i,
   input wire logic handler_done_i,
   input wire logic [2:0] rd_idx_i,
   output logic instr_ready_o,
   output pisx_pkg::pisx_result_t result_o,
   output logic result_valid_o,
   output logic exc_clear_o,
   output logic float_error_pin_n_o,
   output logic [pisx_pkg::FP_REG_W-1:0] rd_data_o,
   output logic [2*pisx_pkg::NUM_REGS-1:0] tags_o,
   output logic [2:0] stack_top_pointer_o
);
   // Prefix bytes arrive packed in one 64-bit word, so at most eight fit
   if (MAX_PFX < 1 || MAX_PFX > 8) begin : g_bad_max_pfx
      $error("pisx_checker: MAX_PFX must be 1 to 8");
   end

   typedef enum logic [2:0] {
      PISX_IDLE = 3'b001,
      PISX_WAIT_HANDLER = 3'b010,
      PISX_RETRY = 3'b100
   } pisx_state_t;

   pisx_state_t state_reg;
   pisx_state_t state_next;

   // ==========================================================================
   // Prefix scan
   logic [MAX_PFX-1:0] hit_lock;
   logic [MAX_PFX-1:0] hit_addr;
   logic [MAX_PFX-1:0] hit_seg;
   logic [2:0] seg_code [MAX_PFX];
   logic [2:0] seg_sel [MAX_PFX+1];

   for (genvar g = 0; g < MAX_PFX; g++) begin : g_pfx
      wire logic [7:0] pb = instr_i.pfx_bytes[8*g +: 8];
      wire logic present = (8'(g) < instr_i.pfx_count);
      assign hit_lock[g] = present && (pb == pisx_pkg::PFX_LOCK);
      assign hit_addr[g] = present && (pb == pisx_pkg::PFX_ADDR_SIZE);
      assign hit_seg[g] = present && (pb == pisx_pkg::PFX_SEG_CS || pb == pisx_pkg::PFX_SEG_SS
         || pb == pisx_pkg::PFX_SEG_DS || pb == pisx_pkg::PFX_SEG_ES
         || pb == pisx_pkg::PFX_SEG_FS || pb == pisx_pkg::PFX_SEG_GS);
      assign seg_code[g] = (pb == pisx_pkg::PFX_SEG_CS) ? pisx_pkg::PISX_SEG_CS :
         (pb == pisx_pkg::PFX_SEG_SS) ? pisx_pkg::PISX_SEG_SS :
         (pb == pisx_pkg::PFX_SEG_ES) ? pisx_pkg::PISX_SEG_ES :
         (pb == pisx_pkg::PFX_SEG_FS) ? pisx_pkg::PISX_SEG_FS :
         (pb == pisx_pkg::PFX_SEG_GS) ? pisx_pkg::PISX_SEG_GS : pisx_pkg::PISX_SEG_DS;
      // Last override wins, as in ordinary decode
      assign seg_sel[g+1] = hit_seg[g] ? seg_code[g] : seg_sel[g];
   end
   assign seg_sel[0] = pisx_pkg::PISX_SEG_DS;

   // Operand-size, repeat and hint bytes are simply not looked at
   wire logic simd = instr_valid_i && instr_i.is_simd;
   wire logic lock_seen = |hit_lock;
   wire logic mem_form = instr_i.has_mem;
   wire logic addr_ovr = mem_form && (|hit_addr);
   wire logic seg_ovr = mem_form && (|hit_seg);
   wire logic [2:0] seg_pick = mem_form ? seg_sel[MAX_PFX] : pisx_pkg::PISX_SEG_DS;
   wire logic any_mem_fault = mem_form && (mem_fault_i.page_fault
      || mem_fault_i.seg_not_present || mem_fault_i.limit_violation);
   wire logic [7:0] mem_vec = mem_fault_i.page_fault ? pisx_pkg::VEC_PAGE_FAULT :
      mem_fault_i.seg_not_present ? pisx_pkg::VEC_SEG_NOT_PRESENT :
      mem_fault_i.stack_seg ? pisx_pkg::VEC_STACK_LIMIT : pisx_pkg::VEC_GEN_PROTECT;

   // Numeric error only from a pending float exception
   wire logic num_err = fp_exc_pending_i && (state_reg == PISX_IDLE);
   wire logic take_instr = simd && (state_reg != PISX_WAIT_HANDLER);
   wire logic fault_now = lock_seen || any_mem_fault || num_err;
   wire logic [7:0] vec_now = lock_seen ? pisx_pkg::VEC_INVALID_OPCODE :
      any_mem_fault ? mem_vec : pisx_pkg::VEC_NUMERIC_ERROR;
   wire logic completes = take_instr && !fault_now;
   wire logic num_taken = take_instr && !lock_seen && !any_mem_fault && num_err;

   // ==========================================================================
   // Pending-exception sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PISX_IDLE: begin
            if (num_taken) begin
               state_next = PISX_WAIT_HANDLER;
            end
         end
         PISX_WAIT_HANDLER: begin
            if (handler_done_i) begin
               state_next = PISX_RETRY;
            end
         end
         PISX_RETRY: begin
            if (take_instr) begin
               state_next = PISX_IDLE;
            end
         end
         default: state_next = PISX_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_reg <= PISX_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================================
   // Registered outcome and error pin
   pisx_pkg::pisx_result_t result_reg;
   logic result_valid_reg;
   logic err_pin_reg;
   logic exc_clear_reg;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         result_reg <= '0;
         result_valid_reg <= 1'b0;
         err_pin_reg <= 1'b0;
         exc_clear_reg <= 1'b0;
      end else begin
         result_valid_reg <= take_instr;
         exc_clear_reg <= handler_done_i && (state_reg == PISX_WAIT_HANDLER);
         if (take_instr) begin
            result_reg.execute <= !fault_now;
            result_reg.fault <= fault_now && (!num_taken || use_int16_i);
            result_reg.vector <= vec_now;
            result_reg.addr_size_32 <= addr_ovr;
            result_reg.seg_override <= seg_ovr;
            result_reg.segment <= seg_pick;
         end
         if (num_taken && use_err_pin_i) begin
            err_pin_reg <= 1'b1;
         end else if (state_reg == PISX_WAIT_HANDLER && handler_done_i) begin
            err_pin_reg <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Aliased state update on completion
   wire logic touch_state = completes && !instr_i.is_empty_instr;
   wire logic empty_state = completes && instr_i.is_empty_instr;
   wire logic reg_write = touch_state && instr_i.writes_reg;
   wire logic [pisx_pkg::FP_REG_W-1:0] wr_word =
      {pisx_pkg::EXP_ALL_ONES, instr_i.result};

   pisx_regfile #(
      .NUM(pisx_pkg::NUM_REGS),
      .WIDTH(pisx_pkg::FP_REG_W)
   ) u_pisx_regfile (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .wr_en_i(reg_write),
      .wr_idx_i(instr_i.dst_reg),
      .wr_data_i(wr_word),
      .tag_all_valid_i(touch_state),
      .tag_all_empty_i(empty_state),
      .top_set_i(touch_state),
      .top_val_i(pisx_pkg::TOP_SIMD),
      .rd_idx_i(rd_idx_i),
      .rd_data_o(rd_data_o),
      .tags_o(tags_o),
      .top_o(stack_top_pointer_o)
   );

   assign instr_ready_o = state_reg != PISX_WAIT_HANDLER;
   assign result_o = result_reg;
   assign result_valid_o = result_valid_reg;
   assign exc_clear_o = exc_clear_reg;
   assign float_error_pin_n_o = !err_pin_reg;
endmodule

/* hw/pisx_pkg.sv */
/*
 Package for the packed-integer SIMD prefix and exception checker.
 Holds prefix byte codes, fault codes, decode carriers and register-file layout.
 Assumes a core that presents one decoded instruction at a time with its prefixes.
*/
package pisx_pkg;

   // ==========================================================================
   // Prefix byte codes
   localparam logic [7:0] PFX_ADDR_SIZE = 8'h67;
   localparam logic [7:0] PFX_OPER_SIZE = 8'h66;
   localparam logic [7:0] PFX_SEG_CS = 8'h2E;
   localparam logic [7:0] PFX_SEG_SS = 8'h36;
   localparam logic [7:0] PFX_SEG_DS = 8'h3E;
   localparam logic [7:0] PFX_SEG_ES = 8'h26;
   localparam logic [7:0] PFX_SEG_FS = 8'h64;
   localparam logic [7:0] PFX_SEG_GS = 8'h65;
   localparam logic [7:0] PFX_REP = 8'hF3;
   localparam logic [7:0] PFX_REPNE = 8'hF2;
   localparam logic [7:0] PFX_LOCK = 8'hF0;

   // ==========================================================================
   // Exception vectors presented to the core
   localparam logic [7:0] VEC_INVALID_OPCODE = 8'h06;
   localparam logic [7:0] VEC_SEG_NOT_PRESENT = 8'h0B;
   localparam logic [7:0] VEC_STACK_LIMIT = 8'h0C;
   localparam logic [7:0] VEC_GEN_PROTECT = 8'h0D;
   localparam logic [7:0] VEC_PAGE_FAULT = 8'h0E;
   localparam logic [7:0] VEC_NUMERIC_ERROR = 8'h10;

   // ==========================================================================
   // Register file layout and reset values
   localparam int NUM_REGS = 8;
   localparam int REG_IDX_W = 3;
   localparam int FP_REG_W = 80;
   localparam int SIMD_W = 64;
   localparam logic [15:0] EXP_ALL_ONES = 16'hFFFF;
   localparam logic [1:0] TAG_VALID = 2'h0;
   localparam logic [1:0] TAG_EMPTY = 2'h3;
   localparam logic [2:0] TOP_RESET = 3'h0;
   localparam logic [2:0] TOP_SIMD = 3'h0;

   // Segment selection codes
   typedef enum logic [2:0] {
      PISX_SEG_ES = 3'h0,
      PISX_SEG_CS = 3'h1,
      PISX_SEG_SS = 3'h2,
      PISX_SEG_DS = 3'h3,
      PISX_SEG_FS = 3'h4,
      PISX_SEG_GS = 3'h5
   } pisx_seg_t;

   // Instruction as presented by the front end
   typedef struct packed {
      logic is_simd;
      logic is_empty_instr;
      logic has_mem;
      logic writes_reg;
      logic [2:0] dst_reg;
      logic [63:0] result;
      logic [7:0] pfx_count;
      logic [63:0] pfx_bytes;
   } pisx_instr_t;

   // Memory-access fault report from the address unit
   typedef struct packed {
      logic page_fault;
      logic seg_not_present;
      logic limit_violation;
      logic stack_seg;
   } pisx_mem_fault_t;

   // Decode outcome
   typedef struct packed {
      logic execute;
      logic fault;
      logic [7:0] vector;
      logic addr_size_32;
      logic seg_override;
      logic [2:0] segment;
   } pisx_result_t;

endpackage

/* hw/pisx_regfile.sv */
/*
 Shared floating-point / packed SIMD register storage with tags and top pointer.
 Assumes writes come from the checker only; read data is registered.
*/
`timescale 1ns/100ps
module pisx_regfile #(
   parameter int NUM = pisx_pkg::NUM_REGS,
   parameter int WIDTH = pisx_pkg::FP_REG_W
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic wr_en_i,
   input wire logic [2:0] wr_idx_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic tag_all_valid_i,
   input wire logic tag_all_empty_i,
   input wire logic top_set_i,
   input wire logic [2:0] top_val_i,
   input wire logic [2:0] rd_idx_i,
   output logic [WIDTH-1:0] rd_data_o,
   output logic [2*NUM-1:0] tags_o,
   output logic [2:0] top_o
);
   if (NUM != 8 || WIDTH < pisx_pkg::SIMD_W + 16) begin : g_bad_size
      $error("pisx_regfile: unsupported size");
   end

   logic [WIDTH-1:0] mem_reg [NUM];
   logic [2*NUM-1:0] tags_reg;
   logic [2:0] top_reg;

   // ==========================================================================
   // One storage for both views of the registers
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_reg[wr_idx_i] <= wr_data_i;
      end
      rd_data_o <= mem_reg[rd_idx_i];
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         tags_reg <= {NUM{pisx_pkg::TAG_EMPTY}};
         top_reg <= pisx_pkg::TOP_RESET;
      end else begin
         if (tag_all_valid_i) begin
            tags_reg <= {NUM{pisx_pkg::TAG_VALID}};
         end else if (tag_all_empty_i) begin
            tags_reg <= {NUM{pisx_pkg::TAG_EMPTY}};
         end
         if (top_set_i) begin
            top_reg <= top_val_i;
         end
      end
   end

   assign tags_o = tags_reg;
   assign top_o = top_reg;
endmodule

/* sim/pisx_checker_tb.sv */
/*
 Self-checking bench for pisx_checker.
 Assumes the checker props file is compiled alongside.
*/
`timescale 1ns/100ps
module pisx_checker_tb;
   logic clk_i = 0, reset_n_i = 0, instr_valid_i = 0, fp_exc_pending_i = 0;
   logic use_int16_i = 0, use_err_pin_i = 0, handler_done_i = 0;
   logic [2:0] rd_idx_i = 3'h0;
   pisx_pkg::pisx_instr_t instr_i = '0;
   pisx_pkg::pisx_mem_fault_t mem_fault_i = '0;
   logic instr_ready_o, result_valid_o, exc_clear_o, float_error_pin_n_o;
   pisx_pkg::pisx_result_t result_o;
   logic [79:0] rd_data_o;
   logic [15:0] tags_o;
   logic [2:0] stack_top_pointer_o;
   logic [7:0] segb [6] = '{8'h26, 8'h2E, 8'h36, 8'h3E, 8'h64, 8'h65};
   pisx_pkg::pisx_instr_t ins;
   int num_errors = 0, n_tests = 0, cycles = 0;
   pisx_checker u_pisx_checker (.clk_i, .reset_n_i, .instr_valid_i, .instr_i, .mem_fault_i,
      .fp_exc_pending_i, .use_int16_i, .use_err_pin_i, .handler_done_i, .rd_idx_i,
      .instr_ready_o, .result_o, .result_valid_o, .exc_clear_o, .float_error_pin_n_o,
      .rd_data_o, .tags_o, .stack_top_pointer_o);
   initial forever #5 clk_i = ~clk_i;
   // =====
   // Common tasks
   task tally_and_finish;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Hang guard: whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   task check(input string what, input logic [79:0] got, input logic [79:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic pisx_pkg::pisx_instr_t mk(logic mem, logic [7:0] cnt, logic [63:0] pb);
      mk = '0;
      mk.is_simd = 1'b1;
      mk.has_mem = mem;
      mk.pfx_count = cnt;
      mk.pfx_bytes = pb;
   endfunction
   task send(input pisx_pkg::pisx_instr_t i, input pisx_pkg::pisx_mem_fault_t mf);
      @(posedge clk_i);
      instr_i <= i;
      mem_fault_i <= mf;
      instr_valid_i <= 1'b1;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
      check("result_valid", result_valid_o, i.is_simd);
   endtask
   // Seg packs addr_size_32, seg_override, segment; vec zero means no fault
   task pcase(logic [7:0] cnt, logic [63:0] pb, logic mem, logic [3:0] mf, logic [7:0] vec,
              logic [4:0] seg);
      send(mk(mem, cnt, pb), mf);
      check("fault_exec", {result_o.fault, result_o.execute}, {vec != 0, vec == 0});
      // Low five bits of the result carry addr_size_32, seg_override and segment
      if (vec != 0) begin
         check("vector", result_o.vector, vec);
      end else begin
         check("addr_seg", result_o[4:0], seg);
      end
   endtask
   // =====
   // Scenarios
   task t_regs;
      check("rst_state", {tags_o, stack_top_pointer_o}, {16'hFFFF, 3'h0});
      ins = mk(1'b0, 8'h00, 64'h0);
      ins.writes_reg = 1'b1;
      ins.dst_reg = 3'h5;
      ins.result = 64'h0123_4567_89AB_CDEF;
      send(ins, 4'h0);
      check("simd_state", {tags_o, stack_top_pointer_o}, 19'h0);
      @(posedge clk_i);
      rd_idx_i <= 3'h5;
      repeat (2) @(posedge clk_i);
      #1;
      check("alias_reg", rd_data_o, {16'hFFFF, ins.result});
      ins.writes_reg = 1'b0;
      ins.is_empty_instr = 1'b1;
      send(ins, 4'h0);
      check("empty_tags", tags_o, 16'hFFFF);
      ins.is_simd = 1'b0;
      send(ins, 4'h0);
      check("ignored_tags", tags_o, 16'hFFFF);
   endtask
   task t_prefix;
      pcase(8'h00, 64'h0, 1'b1, 4'h0, 8'h00, 5'h03);
      pcase(8'h01, 64'hF0, 1'b0, 4'h0, 8'h06, 5'h00);
      pcase(8'h02, 64'hF067, 1'b1, 4'h8, 8'h06, 5'h00);
      pcase(8'h01, 64'hF036, 1'b1, 4'h0, 8'h00, 5'h0A);
      pcase(8'h01, 64'h67, 1'b1, 4'h0, 8'h00, 5'h13);
      pcase(8'h01, 64'h67, 1'b0, 4'h0, 8'h00, 5'h03);
      pcase(8'h02, 64'h6526, 1'b1, 4'h0, 8'h00, 5'h0D);
      pcase(8'h01, 64'h64, 1'b0, 4'h0, 8'h00, 5'h03);
      pcase(8'h03, 64'hF2F366, 1'b0, 4'h0, 8'h00, 5'h03);
      for (int i = 0; i < 6; i++) begin
         pcase(8'h01, {56'h0, segb[i]}, 1'b1, 4'h0, 8'h00, {2'b01, 3'(i)});
      end
      pcase(8'h00, 64'h0, 1'b1, 4'h8, 8'h0E, 5'h00);
      pcase(8'h00, 64'h0, 1'b1, 4'h4, 8'h0B, 5'h00);
      pcase(8'h00, 64'h0, 1'b1, 4'h3, 8'h0C, 5'h00);
      pcase(8'h00, 64'h0, 1'b1, 4'h2, 8'h0D, 5'h00);
   endtask
   // Reset in mid-run while a numeric error holds the pin low and stalls the input
   task t_reset;
      @(posedge clk_i);
      fp_exc_pending_i <= 1'b1;
      use_int16_i <= 1'b1;
      use_err_pin_i <= 1'b1;
      send(mk(1'b0, 8'h00, 64'h0), 4'h0);
      check("wait_state", {instr_ready_o, float_error_pin_n_o}, 2'b00);
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      fp_exc_pending_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      #1;
      check("reset_ctl", {instr_ready_o, float_error_pin_n_o, result_valid_o}, 3'b110);
      check("reset_state", {tags_o, stack_top_pointer_o, result_o},
            {16'hFFFF, 3'h0, 15'h0000});
   endtask
   task t_numeric(input logic i16, input logic pin);
      @(posedge clk_i);
      fp_exc_pending_i <= 1'b1;
      use_int16_i <= i16;
      use_err_pin_i <= pin;
      send(mk(1'b0, 8'h00, 64'h0), 4'h0);
      check("num_fault", {result_o.fault, result_o.execute, float_error_pin_n_o},
            {i16, 1'b0, !pin});
      if (i16) check("num_vec", result_o.vector, 8'h10);
      repeat (3) @(posedge clk_i);
      check("refused", instr_ready_o, 1'b0);
      handler_done_i <= 1'b1;
      @(posedge clk_i);
      handler_done_i <= 1'b0;
      #1;
      check("clear", {exc_clear_o, float_error_pin_n_o, instr_ready_o}, 3'b111);
      send(mk(1'b0, 8'h00, 64'h0), 4'h0);
      check("retry", {result_o.fault, result_o.execute}, 2'b01);
      @(posedge clk_i);
      fp_exc_pending_i <= 1'b0;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      #1;
      t_regs();
      t_prefix();
      t_reset();
      t_numeric(1'b1, 1'b1);
      t_numeric(1'b1, 1'b0);
      t_numeric(1'b0, 1'b1);
      tally_and_finish();
   end
endmodule

/* sim/pisx_props.sv */
/*
 Port checker for the packed SIMD prefix and exception checker.
 Assumes it is bound to every pisx_checker instance.
*/
`timescale 1ns/100ps
module pisx_props (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic instr_valid_i,
   input wire pisx_pkg::pisx_instr_t instr_i,
   input wire pisx_pkg::pisx_mem_fault_t mem_fault_i,
   input wire logic fp_exc_pending_i,
   input wire logic use_err_pin_i,
   input wire logic handler_done_i,
   input wire logic instr_ready_o,
   input wire pisx_pkg::pisx_result_t result_o,
   input wire logic result_valid_o,
   input wire logic exc_clear_o,
   input wire logic float_error_pin_n_o,
   input wire logic [15:0] tags_o,
   input wire logic [2:0] stack_top_pointer_o
);
   wire take = instr_valid_i && instr_i.is_simd && instr_ready_o;
   wire rv = result_valid_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // =====
   // Assertions and covers
   a_take_answers: assert property (take |=> rv) else $error("no result after take");
   a_no_stray: assert property ($rose(rv) |-> $past(take)) else $error("stray result");
   a_page_vector: assert property (rv && result_o.fault && result_o.vector != 8'h06 &&
      $past(instr_i.has_mem && mem_fault_i.page_fault) |-> result_o.vector == 8'h0E)
      else $error("page fault vector wrong");
   a_quiet_numeric: assert property (rv && !$past(fp_exc_pending_i) |->
      !(result_o.fault && result_o.vector == 8'h10) && float_error_pin_n_o)
      else $error("numeric error without pending exception");
   a_pin_blocks: assert property (!float_error_pin_n_o |-> !instr_ready_o)
      else $error("ready while error pin low");
   a_pin_cause: assert property ($fell(float_error_pin_n_o) |->
      rv && $past(use_err_pin_i && fp_exc_pending_i)) else $error("pin fell without cause");
   a_clear_resumes: assert property (handler_done_i && !instr_ready_o |=>
      exc_clear_o && instr_ready_o && float_error_pin_n_o) else $error("no resume");
   a_fault_no_exec: assert property (rv && result_o.fault |-> !result_o.execute)
      else $error("faulted instruction executed");
   a_simd_tags: assert property (rv && result_o.execute
      && !$past(instr_i.is_empty_instr) |-> tags_o == 16'h0000 && stack_top_pointer_o == 3'h0)
      else $error("tags not valid");
   a_empty_tags: assert property (rv && result_o.execute
      && $past(instr_i.is_empty_instr) |-> tags_o == 16'hFFFF) else $error("tags not empty");
   c_mem: cover property (take && instr_i.has_mem);
   c_fault: cover property (rv && result_o.fault);
   c_clear: cover property (exc_clear_o);
endmodule
bind pisx_checker pisx_props u_pisx_props (.clk_i, .reset_n_i, .instr_valid_i, .instr_i,
   .mem_fault_i, .fp_exc_pending_i, .use_err_pin_i, .handler_done_i, .instr_ready_o,
   .result_o, .result_valid_o, .exc_clear_o, .float_error_pin_n_o, .tags_o,
   .stack_top_pointer_o);
